/* reset_wake_pkg.sv */
// Constants shared by the reset and wake sequencer.
// Assumes a 100 MHz system clock and a 32.768 kHz crystal clock input.
package reset_wake_pkg;

  // ==========================================================
  // Clock rates
  localparam int SYS_CLK_PERIOD_NS = 10;     // 100 MHz
  localparam int SLOW_TICKS_PER_HZ = 32768;  // Crystal periods per 1 Hz

  // ==========================================================
  // Waits, in crystal periods unless stated
  localparam int          PLL_LOCK_NS   = 250000;  // PLL lock time, ns
  localparam int          PLL_LOCK_CYC  = PLL_LOCK_NS / SYS_CLK_PERIOD_NS;
  localparam int          HZ_HOLD_TICKS = 2 * SLOW_TICKS_PER_HZ;
  localparam logic [16:0] UR_HOLD_TICKS = 17'h00002;  // After user reset
  localparam logic [2:0]  ASSERT_TICKS  = 3'h3;       // Inside 2..4 window
  localparam logic [2:0]  PF_PULSE_LAST = 3'h4;       // Two-period pulse
  localparam logic [2:0]  WAKE_TICKS    = 3'h3;       // Wake to enable
  localparam logic [2:0]  CNT_SAT       = 3'h7;

  // ==========================================================
  // Synchroniser reset values
  // Bit order: ur, pf, crystal, wake, osc, battery, ext power.
  // Crystal and wake idle low so that no false tick or wake follows reset.
  localparam logic [6:0] SYNC_INIT = 7'h43;  // Low-active inputs idle high

endpackage : reset_wake_pkg

/* sync_filter.sv */
// Three-stage synchroniser; output moves once stages two and three agree.
// Assumes inputs are asynchronous to clk.
module sync_filter #(
  parameter int         W    = 1,
  parameter logic [6:0] INIT = 7'h00
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] filt_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ==========================================================
  // Per-bit chain
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[i]     <= INIT[i];
          s2_q[i]     <= INIT[i];
          s3_q[i]     <= INIT[i];
          filt_out[i] <= INIT[i];
        end else begin
          s1_q[i] <= async_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            filt_out[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

endmodule : sync_filter

/* reset_wake_sequencer.sv */
// Reset, wake and oscillator-enable sequencer for three reset sources.
// Assumes board pins arrive asynchronously; power-on reset acts directly.
// Behaviour
// - Battery and external-power inputs are sampled in that window.
// - PLL clocks count as usable 250 us after the fast oscillator is stable with the enable on.
// - Wake held 4 crystal periods turns on the enable after 2 to 4 periods once the wake hold-off has run out.
// - Power-on reset drives the reset output directly; release waits for a sys_clk edge.
// - User reset held 4 periods asserts reset output after 2 to 4 periods.
// - Reset output is released 0 to 2 periods after user reset release.
// - The enable drops 2 to 4 periods after user reset goes low.
// - Power fail held 4 periods gives a 2-period reset pulse after 2 to 4.
// - The enable drops 2 to 4 periods after power fail goes low.
module reset_wake_sequencer
  import reset_wake_pkg::*;
#(
  parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC,
  parameter int HZ_HOLD         = HZ_HOLD_TICKS
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Board supervision pins
  input  wire logic power_on_reset_n,
  input  wire logic user_reset_n,
  input  wire logic power_fail_n,
  input  wire logic wake_request,
  input  wire logic slow_crystal_clock,
  input  wire logic fast_osc_stable,
  input  wire logic battery_good,
  input  wire logic external_power_present_n,
  // Sequenced outputs
  output logic      system_reset_out_n,
  output logic      oscillator_enable_out,
  output logic      pll_ready,
  output logic      wake_permitted,
  output logic      battery_good_sampled,
  output logic      external_power_sampled_n
);

  // Power-on reset clears everything asynchronously
  wire rst_n = resetn & power_on_reset_n;

  logic [6:0]  sync_s;
  logic        slow_prev_q;
  logic [2:0]  ur_cnt_q;
  logic [2:0]  pf_cnt_q;
  logic [2:0]  wk_cnt_q;
  logic [16:0] hold_q;
  logic        por_win_q;
  logic        pf_prev_q;
  logic        ur_prev_q;
  logic [15:0] lock_cnt_q;

  // ==========================================================
  // Input synchronisers
  sync_filter #(
    .W    (7),
    .INIT (SYNC_INIT)
  ) u_sync (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .async_in ({external_power_present_n, battery_good, fast_osc_stable,
                wake_request, slow_crystal_clock, power_fail_n,
                user_reset_n}),
    .filt_out (sync_s)
  );

  wire ur_s    = sync_s[0];
  wire pf_s    = sync_s[1];
  wire slow_s  = sync_s[2];
  wire wake_s  = sync_s[3];
  wire osc_s   = sync_s[4];
  wire batt_s  = sync_s[5];
  wire extpw_s = sync_s[6];

  // ==========================================================
  // Crystal period enable and decodes
  wire slow_tick = slow_s & ~slow_prev_q;
  wire ur_hit    = ~ur_s & (ur_cnt_q >= ASSERT_TICKS);
  wire pf_hit    = pf_cnt_q >= ASSERT_TICKS;
  wire pf_pulse  = pf_hit & (pf_cnt_q <= PF_PULSE_LAST);
  wire wake_ok   = wake_s & (wk_cnt_q >= WAKE_TICKS) & (hold_q == 17'h00000);
  wire lock_done = lock_cnt_q == 16'(PLL_LOCK_CYCLES - 1);

  // Saturating count of crystal periods while a level holds
  function automatic logic [2:0] run_count(input logic active,
                                           input logic tick,
                                           input logic [2:0] cnt);
    if (!active) begin
      return 3'h0;
    end
    if (tick && cnt != CNT_SAT) begin
      return cnt + 3'h1;
    end
    return cnt;
  endfunction : run_count

  // ==========================================================
  // Low-time counters for user reset and power fail, high-time counter for wake
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_prev_q <= 1'b0;
      ur_cnt_q    <= 3'h0;
      pf_cnt_q    <= 3'h0;
      wk_cnt_q    <= 3'h0;
      ur_prev_q   <= 1'b1;
      pf_prev_q   <= 1'b1;
    end else begin
      slow_prev_q <= slow_s;
      ur_cnt_q    <= run_count(~ur_s, slow_tick, ur_cnt_q);
      pf_cnt_q    <= run_count(~pf_s, slow_tick, pf_cnt_q);
      wk_cnt_q    <= run_count(wake_s, slow_tick, wk_cnt_q);
      ur_prev_q   <= ur_s;
      pf_prev_q   <= pf_s;
    end
  end

  // ==========================================================
  // Wake hold-off after power-on, user reset and power fail release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q    <= 17'(HZ_HOLD);
      por_win_q <= 1'b1;
    end else if (pf_s && !pf_prev_q) begin
      hold_q    <= 17'(HZ_HOLD);
    end else if (ur_s && !ur_prev_q) begin
      hold_q    <= UR_HOLD_TICKS;
    end else if (slow_tick && hold_q != 17'h00000) begin
      hold_q    <= hold_q - 17'h00001;
    end else if (hold_q == 17'h00000) begin
      por_win_q <= 1'b0;
    end
  end

  // ==========================================================
  // Battery and external power sampled during the power-on window
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      battery_good_sampled     <= 1'b0;
      external_power_sampled_n <= 1'b1;
    end else if (por_win_q && slow_tick) begin
      battery_good_sampled     <= batt_s;
      external_power_sampled_n <= extpw_s;
    end
  end

  // ==========================================================
  // Reset output, oscillator enable and wake permission
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      system_reset_out_n    <= 1'b0;
      oscillator_enable_out <= 1'b0;
      wake_permitted        <= 1'b0;
    end else begin
      system_reset_out_n <= ~(ur_hit | pf_pulse);
      wake_permitted     <= hold_q == 17'h00000;
      if (ur_hit || pf_hit) begin
        oscillator_enable_out <= 1'b0;
      end else if (wake_ok) begin
        oscillator_enable_out <= 1'b1;
      end
    end
  end

  // ==========================================================
  // PLL lock wait once the fast oscillator runs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_q <= 16'h0000;
      pll_ready  <= 1'b0;
    end else if (!osc_s || !oscillator_enable_out) begin
      lock_cnt_q <= 16'h0000;
      pll_ready  <= 1'b0;
    end else if (lock_done) begin
      pll_ready  <= 1'b1;
    end else begin
      lock_cnt_q <= lock_cnt_q + 16'h0001;
    end
  end

  // ==========================================================
  // Checks
  a_ur_reset_assert: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!ur_s && ur_cnt_q >= ASSERT_TICKS) |=> !system_reset_out_n)
    else $error("reset output not asserted after user reset");
  a_ur_reset_release: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (ur_s && !pf_pulse) |=> system_reset_out_n)
    else $error("reset output held after user reset release");
  a_ur_osc_drop: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ur_hit |=> !oscillator_enable_out)
    else $error("enable kept during user reset");
  a_pf_osc_drop: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    pf_hit |=> !oscillator_enable_out)
    else $error("enable kept during power fail");
  a_pf_pulse_start: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (pf_cnt_q == ASSERT_TICKS) |=> !system_reset_out_n)
    else $error("power fail pulse missing");
  a_pf_pulse_end: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (pf_cnt_q > PF_PULSE_LAST && !ur_hit) |=> system_reset_out_n)
    else $error("power fail pulse too long");
  a_wake_osc_delay: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(oscillator_enable_out) |-> $past(wk_cnt_q) >= WAKE_TICKS)
    else $error("enable raised too early after wake");
  a_wake_hold_off: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(oscillator_enable_out) |-> $past(hold_q) == 17'h00000)
    else $error("wake honoured inside hold-off");
  a_pll_lock_wait: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(pll_ready) |-> $past(lock_cnt_q) == 16'(PLL_LOCK_CYCLES - 1))
    else $error("pll ready before lock time");
  a_por_sample: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (por_win_q && slow_tick) |=> battery_good_sampled == $past(batt_s))
    else $error("battery not sampled in window");

endmodule : reset_wake_sequencer

/* board_supervisor.sv */
// Board model: free-running crystal and the power-on reset circuit.
// Assumes the bench drives the other pins and may pull power-on low.
module board_supervisor #(
  parameter int XTAL_HALF_NS = 100
) (
  // Bench request
  input  wire logic por_req_n,
  // Pins to the sequencer
  output logic      slow_crystal_clock,
  output logic      power_on_reset_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic xtal_stable = 1'b0;
  // Crystal runs free once powered
  initial slow_crystal_clock = 1'b0;
  always #(XTAL_HALF_NS) slow_crystal_clock = ~slow_crystal_clock;
  // Power-on stays low until the crystal has run a few periods
  initial begin
    repeat (4) @(posedge slow_crystal_clock);
    xtal_stable = 1'b1;
  end
  assign power_on_reset_n = xtal_stable & por_req_n;
endmodule : board_supervisor

/* tb_reset_wake_sequencer.sv */
// Self-checking bench for the reset and wake sequencer.
// Assumes a crystal of 20 sys_clk periods and shortened waits.
module tb_reset_wake_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 20;  // sys_clk cycles per crystal period
  localparam int LOCK = 20;
  localparam int HOLD = 8;
  logic sys_clk = 1'b0, resetn = 1'b0, por_req_n = 1'b1;
  logic user_reset_n = 1'b1, power_fail_n = 1'b1, wake_request = 1'b0;
  logic fast_osc_stable = 1'b0, battery_good = 1'b1;
  logic external_power_present_n = 1'b0;
  logic slow_crystal_clock, power_on_reset_n, system_reset_out_n;
  logic oscillator_enable_out, pll_ready, wake_permitted;
  logic battery_good_sampled, external_power_sampled_n;
  int   bad_count = 0, n_tests = 0, cyc = 0, n;
  wire [2:0] obs = {pll_ready, oscillator_enable_out, system_reset_out_n};
  // ==========================================================
  // Clock, models and design
  always #5 sys_clk = ~sys_clk;
  board_supervisor #(.XTAL_HALF_NS(P * 5)) sup (.por_req_n(por_req_n),
    .slow_crystal_clock(slow_crystal_clock),
    .power_on_reset_n(power_on_reset_n));
  reset_wake_sequencer #(.PLL_LOCK_CYCLES(LOCK), .HZ_HOLD(HOLD)) DUT (
    .sys_clk(sys_clk), .resetn(resetn), .power_on_reset_n(power_on_reset_n),
    .user_reset_n(user_reset_n), .power_fail_n(power_fail_n),
    .wake_request(wake_request), .slow_crystal_clock(slow_crystal_clock),
    .fast_osc_stable(fast_osc_stable), .battery_good(battery_good),
    .external_power_present_n(external_power_present_n),
    .system_reset_out_n(system_reset_out_n),
    .oscillator_enable_out(oscillator_enable_out), .pll_ready(pll_ready),
    .wake_permitted(wake_permitted),
    .battery_good_sampled(battery_good_sampled),
    .external_power_sampled_n(external_power_sampled_n));
  // ==========================================================
  // Helpers
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk_bit(string what, logic exp, logic got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_span(string what, int lo, int hi, int got);
    n_tests++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_span
  // Cycles until an observed output reaches a level
  task automatic wait_for(int sel, logic v, output int k);
    k = 0;
    while (obs[sel] !== v && k < 400) begin
      @(posedge sys_clk);
      k++;
    end
  endtask : wait_for
  task automatic ticks(int k);
    repeat (k) @(posedge slow_crystal_clock);
    @(posedge sys_clk);
  endtask : ticks
  // ==========================================================
  // Scenarios
  task automatic t_power_on();
    wait (power_on_reset_n === 1'b1);
    wait_for(0, 1'b1, n);
    chk_span("reset release", 0, 3, n);
    wake_request <= 1'b1;
    ticks(5);
    wake_request <= 1'b0;
    chk_bit("enable in hold-off", 1'b0, oscillator_enable_out);
    ticks(HOLD);
    chk_bit("wake permitted", 1'b1, wake_permitted);
    battery_good <= 1'b0;
    external_power_present_n <= 1'b1;
    ticks(2);
    chk_bit("battery sampled", 1'b1, battery_good_sampled);
    chk_bit("ext power sampled", 1'b0, external_power_sampled_n);
    $display("done power_on");
  endtask : t_power_on
  task automatic t_wake();
    wake_request <= 1'b1;
    wait_for(1, 1'b1, n);
    chk_span("wake to enable", 2 * P, 4 * P + 10, n);
    ticks(3);
    wake_request <= 1'b0;
    $display("done wake");
  endtask : t_wake
  task automatic t_pll();
    fast_osc_stable <= 1'b1;
    wait_for(2, 1'b1, n);
    chk_span("pll lock", LOCK, LOCK + 8, n);
    $display("done pll");
  endtask : t_pll
  task automatic t_user_reset();
    user_reset_n <= 1'b0;
    wait_for(0, 1'b0, n);
    chk_span("user reset assert", 2 * P, 4 * P + 10, n);
    chk_bit("enable after user reset", 1'b0, oscillator_enable_out);
    ticks(4);
    user_reset_n <= 1'b1;
    wait_for(0, 1'b1, n);
    chk_span("user reset release", 0, 2 * P, n);
    ticks(3);
    $display("done user_reset");
  endtask : t_user_reset
  task automatic t_power_fail();
    power_fail_n <= 1'b0;
    wait_for(0, 1'b0, n);
    chk_span("power fail assert", 2 * P, 4 * P + 10, n);
    chk_bit("enable after power fail", 1'b0, oscillator_enable_out);
    wait_for(0, 1'b1, n);
    chk_span("power fail pulse", 2 * P - 2, 2 * P + 2, n);
    ticks(2);
    power_fail_n <= 1'b1;
    wake_request <= 1'b1;
    ticks(4);
    wake_request <= 1'b0;
    chk_bit("enable after fail hold-off", 1'b0, oscillator_enable_out);
    $display("done power_fail");
  endtask : t_power_fail
  task automatic t_por_mid();
    por_req_n <= 1'b0;
    #1;
    chk_bit("reset on power-on", 1'b0, system_reset_out_n);
    @(posedge sys_clk);
    por_req_n <= 1'b1;
    wait_for(0, 1'b1, n);
    chk_span("reset release mid", 0, 3, n);
    chk_bit("hold-off after power-on", 1'b0, wake_permitted);
    $display("done por_mid");
  endtask : t_por_mid
  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t_power_on();
    t_wake();
    t_pll();
    t_user_reset();
    t_wake();
    t_power_fail();
    t_por_mid();
    give_verdict();
  end
endmodule : tb_reset_wake_sequencer
